// ### design/cre_arbiter.sv
// Fixed priority selection among interrupt sources
`timescale 1ns/10ps
`default_nettype none
module cre_arbiter (
  cre_arb_if.arb a
);
  // req[4]=trap, [3]=wakeup, [2]=timer0, [1]=pwm, [0]=converter
  always_comb begin
    a.any = |a.req;
    a.src = 3'h0;
    if (a.req[4]) begin
      a.src = 3'h5;
    end else if (a.req[3]) begin
      a.src = 3'h4;
    end else if (a.req[2]) begin
      a.src = 3'h3;
    end else if (a.req[1]) begin
      a.src = 3'h2;
    end else if (a.req[0]) begin
      a.src = 3'h1;
    end
  end
endmodule
`default_nettype wire

// ### design/cre_core_regs.sv
// Core registers, flags, stack and interrupt entry sequencer
`timescale 1ns/10ps
`default_nettype none
module cre_core_regs (
  input  wire logic         core_clk,
  input  wire logic         rst_n,
  input  wire logic         instr_done,
  input  wire cre_pkg::cre_op_t op,
  input  wire logic [9:0]   call_target,
  input  wire logic [9:0]   next_pc,
  input  wire logic         alu_upd,
  input  wire logic         alu_upd_c,
  input  wire logic         alu_upd_h,
  input  wire logic [7:0]   alu_result,
  input  wire logic         alu_carry,
  input  wire logic         alu_half,
  input  wire logic         ldc_bit,
  input  wire logic         rot_upd,
  input  wire logic         rot_carry,
  input  wire logic         acc_we,
  input  wire logic [7:0]   acc_wdata,
  input  wire logic         idx_load,
  input  wire logic [10:0]  idx_wdata,
  input  wire logic [7:0]   idx_offset,
  input  wire logic         ee_ready,
  input  wire logic         wakeup_irq,
  input  wire logic         first_timer_irq,
  input  wire logic         pwm_timer_irq,
  input  wire logic         converter_irq,
  input  wire logic         mem_we,
  input  wire logic [7:0]   mem_addr,
  input  wire logic [7:0]   mem_wdata,
  output logic [7:0]        mem_rdata,
  output logic              mem_hit,
  input  wire logic [7:0]   bus_rdata,
  output logic [11:0]       bus_addr,
  output logic [7:0]        bus_wdata,
  output logic              bus_we,
  output logic              bus_re,
  output logic [11:0]       eff_addr,
  output logic [7:0]        acc_ff,
  output logic [9:0]        fetch_location_ff,
  output logic [10:0]       idx_ff,
  output logic [3:0]        stack_index_ff,
  output logic [7:0]        flags_word,
  output logic              seq_busy,
  output logic [2:0]        serving_src_ff
);
  cre_arb_if arb_bus ();
  cre_arbiter u_arb (
    .a (arb_bus.arb)
  );

  cre_pkg::cre_state_t state_ff;
  cre_pkg::cre_state_t nxt_state;
  logic [7:0]  ret_hi_ff;
  logic [3:0]  flag_ff;
  logic        g_ff;
  logic [7:0]  vec_lo_ff;
  logic [2:0]  cyc_ff;
  logic        trap_ff;
  logic        is_handler_exit_op_ff;
  logic        call_ff;
  logic [9:0]  tgt_ff;
  logic        call_now;

  function automatic logic [7:0] stack_addr(input logic [3:0] sp);
    stack_addr = cre_pkg::STACK_BASE | {4'h0, sp};
  endfunction

  // Vector location per source, two bytes each
  function automatic logic [11:0] vec_addr(input logic [2:0] s);
    vec_addr = cre_pkg::VEC_BASE + {8'h00, s - 3'h1, 1'b0};
  endfunction

  assign flags_word = {2'b00, ee_ready, g_ff, flag_ff};
  assign seq_busy   = (state_ff != cre_pkg::CRE_ST_RUN);
  assign call_now   = instr_done && op == cre_pkg::CRE_OP_CALL &&
                      state_ff == cre_pkg::CRE_ST_RUN;

  // Sources; trap ignores mask, others gated by it
  always_comb begin
    arb_bus.req[4] = trap_ff;
    arb_bus.req[3] = wakeup_irq & g_ff;
    arb_bus.req[2] = first_timer_irq & g_ff;
    arb_bus.req[1] = pwm_timer_irq & g_ff;
    arb_bus.req[0] = converter_irq & g_ff;
  end

  // Indexed effective address; bit 10 picks space
  always_comb begin
    logic [10:0] sum;
    sum = idx_ff + {3'h0, idx_offset};
    if (idx_ff[10]) begin
      eff_addr = cre_pkg::PROG_BASE | {2'b00, sum[9:0]};
    end else begin
      eff_addr = {2'b00, sum[9:0]};
    end
  end

  // Memory mapped reads; accumulator and counter not mapped
  always_comb begin
    mem_hit   = 1'b1;
    mem_rdata = 8'h00;
    case (mem_addr)
      cre_pkg::ADDR_IDX_HI: mem_rdata = {5'h00, 1'b0, idx_ff[9:8]};
      cre_pkg::ADDR_IDX_LO: mem_rdata = idx_ff[7:0];
      cre_pkg::ADDR_STACK:  mem_rdata = {4'h0, stack_index_ff};
      cre_pkg::ADDR_FLAGS:  mem_rdata = flags_word;
      default:              mem_hit = 1'b0;
    endcase
  end

  // Sequencer next state
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      cre_pkg::CRE_ST_RUN: begin
        if (instr_done && (op == cre_pkg::CRE_OP_RET ||
                           op == cre_pkg::CRE_OP_HANDLER_EXIT_OP)) begin
          nxt_state = cre_pkg::CRE_ST_PULLH;
        end else if (call_now) begin
          nxt_state = cre_pkg::CRE_ST_PUSHL;
        end else if (instr_done && arb_bus.any) begin
          nxt_state = cre_pkg::CRE_ST_PUSHL;
        end
      end
      cre_pkg::CRE_ST_PUSHL: nxt_state = cre_pkg::CRE_ST_PUSHH;
      cre_pkg::CRE_ST_PUSHH: begin
        nxt_state = call_ff ? cre_pkg::CRE_ST_RUN : cre_pkg::CRE_ST_VECL;
      end
      cre_pkg::CRE_ST_VECL:  nxt_state = cre_pkg::CRE_ST_VECH;
      cre_pkg::CRE_ST_VECH: begin
        if (cyc_ff == 3'(cre_pkg::ENTRY_CYCLES - 1)) begin
          nxt_state = cre_pkg::CRE_ST_RUN;
        end
      end
      cre_pkg::CRE_ST_PULLH: nxt_state = cre_pkg::CRE_ST_PULLL;
      cre_pkg::CRE_ST_PULLL: nxt_state = cre_pkg::CRE_ST_RUN;
      default:               nxt_state = cre_pkg::CRE_ST_RUN;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= cre_pkg::CRE_ST_RUN;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Entry cycle count
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cyc_ff <= 3'h0;
    end else if (nxt_state == cre_pkg::CRE_ST_PUSHL &&
                 state_ff == cre_pkg::CRE_ST_RUN) begin
      cyc_ff <= 3'h0;
    end else if (state_ff != cre_pkg::CRE_ST_RUN &&
                 cyc_ff != 3'(cre_pkg::ENTRY_CYCLES - 1)) begin
      cyc_ff <= cyc_ff + 3'h1;
    end
  end

  // Source latched at entry
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      serving_src_ff <= 3'h0;
    end else if (state_ff == cre_pkg::CRE_ST_RUN &&
                 nxt_state == cre_pkg::CRE_ST_PUSHL && !call_now) begin
      serving_src_ff <= arb_bus.src;
    end
  end

  // Pending soft trap, cleared once entry begins
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      trap_ff <= 1'b0;
    end else if (instr_done && op == cre_pkg::CRE_OP_TRAP) begin
      trap_ff <= 1'b1;
    end else if (state_ff == cre_pkg::CRE_ST_PUSHL && !call_ff &&
                 serving_src_ff == 3'h5) begin
      trap_ff <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      is_handler_exit_op_ff <= 1'b0;
    end else if (instr_done && state_ff == cre_pkg::CRE_ST_RUN) begin
      is_handler_exit_op_ff <= (op == cre_pkg::CRE_OP_HANDLER_EXIT_OP);
    end
  end

  // Subroutine call push in progress, with its target
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      call_ff <= 1'b0;
      tgt_ff  <= 10'h000;
    end else if (state_ff == cre_pkg::CRE_ST_RUN) begin
      call_ff <= call_now;
      tgt_ff  <= call_target;
    end
  end

  // Stack memory bus: push low byte first, pull reverse
  always_comb begin
    logic [9:0] ret;
    ret = fetch_location_ff;
    bus_addr  = 12'h000;
    bus_wdata = 8'h00;
    bus_we    = 1'b0;
    bus_re    = 1'b0;
    case (state_ff)
      cre_pkg::CRE_ST_PUSHL: begin
        bus_addr  = {4'h0, stack_addr(stack_index_ff)};
        bus_wdata = ret[7:0];
        bus_we    = 1'b1;
      end
      cre_pkg::CRE_ST_PUSHH: begin
        bus_addr  = {4'h0, stack_addr(stack_index_ff - 4'h1)};
        bus_wdata = {6'h00, ret[9:8]};
        bus_we    = 1'b1;
      end
      cre_pkg::CRE_ST_VECL: begin
        bus_addr = vec_addr(serving_src_ff);
        bus_re   = 1'b1;
      end
      cre_pkg::CRE_ST_VECH: begin
        bus_addr = vec_addr(serving_src_ff) + 12'h001;
        bus_re   = (cyc_ff == 3'h4);
      end
      cre_pkg::CRE_ST_PULLH: begin
        bus_addr = {4'h0, stack_addr(stack_index_ff + 4'h1)};
        bus_re   = 1'b1;
      end
      cre_pkg::CRE_ST_PULLL: begin
        bus_addr = {4'h0, stack_addr(stack_index_ff + 4'h2)};
        bus_re   = 1'b1;
      end
      default: begin
        bus_re = 1'b0;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      vec_lo_ff <= 8'h00;
      ret_hi_ff <= 8'h00;
    end else if (state_ff == cre_pkg::CRE_ST_VECL) begin
      vec_lo_ff <= bus_rdata;
    end else if (state_ff == cre_pkg::CRE_ST_PULLH) begin
      ret_hi_ff <= bus_rdata;
    end
  end

  // Program counter
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      fetch_location_ff <= cre_pkg::PC_RESET[9:0];
    end else if (state_ff == cre_pkg::CRE_ST_VECH && cyc_ff == 3'h4) begin
      fetch_location_ff <= {bus_rdata[1:0], vec_lo_ff};
    end else if (state_ff == cre_pkg::CRE_ST_PULLL) begin
      fetch_location_ff <= {ret_hi_ff[1:0], bus_rdata};
    end else if (state_ff == cre_pkg::CRE_ST_PUSHH && call_ff) begin
      fetch_location_ff <= tgt_ff;
    end else if (state_ff == cre_pkg::CRE_ST_RUN && instr_done) begin
      fetch_location_ff <= next_pc;
    end
  end

  // Stack index; call pushes via one push of two bytes
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      stack_index_ff <= cre_pkg::SP_RESET;
    end else if (state_ff == cre_pkg::CRE_ST_PUSHH) begin
      stack_index_ff <= stack_index_ff - 4'h2;
    end else if (state_ff == cre_pkg::CRE_ST_PULLL) begin
      stack_index_ff <= stack_index_ff + 4'h2;
    end else if (mem_we && mem_addr == cre_pkg::ADDR_STACK) begin
      stack_index_ff <= mem_wdata[3:0];
    end
  end

  // Index pointer; top bit write only
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      idx_ff <= 11'h000;
    end else if (idx_load) begin
      idx_ff <= idx_wdata;
    end else if (mem_we && mem_addr == cre_pkg::ADDR_IDX_HI) begin
      idx_ff[10:8] <= mem_wdata[2:0];
    end else if (mem_we && mem_addr == cre_pkg::ADDR_IDX_LO) begin
      idx_ff[7:0] <= mem_wdata;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_ff <= 8'h00;
    end else if (acc_we) begin
      acc_ff <= acc_wdata;
    end
  end

  // Condition flags
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_ff <= 4'h0;
    end else if (instr_done && state_ff == cre_pkg::CRE_ST_RUN) begin
      case (op)
        cre_pkg::CRE_OP_SC: begin
          flag_ff[cre_pkg::FLAG_C] <= 1'b1;
          flag_ff[cre_pkg::FLAG_H] <= 1'b1;
        end
        cre_pkg::CRE_OP_RC: begin
          flag_ff[cre_pkg::FLAG_C] <= 1'b0;
          flag_ff[cre_pkg::FLAG_H] <= 1'b0;
        end
        cre_pkg::CRE_OP_LDC:  flag_ff[cre_pkg::FLAG_C] <= ldc_bit;
        cre_pkg::CRE_OP_FLAG_INVERT_OP:
          flag_ff[cre_pkg::FLAG_C] <= ~flag_ff[cre_pkg::FLAG_C];
        default: begin
          if (alu_upd) begin
            flag_ff[cre_pkg::FLAG_Z] <= (alu_result == 8'h00);
            flag_ff[cre_pkg::FLAG_N] <= alu_result[7];
          end
          if (alu_upd_c) begin
            flag_ff[cre_pkg::FLAG_C] <= alu_carry;
          end
          if (alu_upd_h) begin
            flag_ff[cre_pkg::FLAG_H] <= alu_half;
          end
          if (rot_upd) begin
            flag_ff[cre_pkg::FLAG_C] <= rot_carry;
          end
        end
      endcase
    end
  end

  // Global mask
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      g_ff <= 1'b0;
    end else if (state_ff == cre_pkg::CRE_ST_VECH && cyc_ff == 3'h4) begin
      g_ff <= 1'b0;
    end else if (state_ff == cre_pkg::CRE_ST_PULLL && is_handler_exit_op_ff) begin
      g_ff <= 1'b1;
    end else if (instr_done && op == cre_pkg::CRE_OP_GSET) begin
      g_ff <= 1'b1;
    end else if (mem_we && mem_addr == cre_pkg::ADDR_FLAGS) begin
      g_ff <= mem_wdata[cre_pkg::FLAG_G];
    end
  end
endmodule
`default_nettype wire

// ### inc/cre_arb_if.sv
// Interface between sequencer and priority arbiter
`timescale 1ns/10ps
`default_nettype none
interface cre_arb_if;
  logic [4:0] req;
  logic [2:0] src;
  logic       any;
  modport arb (input req, output src, output any);
  modport seq (output req, input src, input any);
endinterface
`default_nettype wire

// ### inc/cre_pkg.sv
// Shared constants and types for the core register and interrupt entry block
package cre_pkg;
  localparam logic [7:0]  ADDR_IDX_HI   = 8'hbe;
  localparam logic [7:0]  ADDR_IDX_LO   = 8'hbf;
  localparam logic [7:0]  ADDR_STACK    = 8'hbd;
  localparam logic [7:0]  ADDR_FLAGS    = 8'hbc;
  localparam logic [11:0] PC_RESET      = 12'hc00;
  localparam logic [3:0]  SP_RESET      = 4'hf;
  localparam logic [7:0]  STACK_BASE    = 8'h30;
  localparam logic [11:0] PROG_BASE     = 12'hc00;
  localparam logic [11:0] VEC_BASE      = 12'hff6;
  localparam int          ENTRY_CYCLES  = 5;
  localparam int          FLAG_C        = 0;
  localparam int          FLAG_H        = 1;
  localparam int          FLAG_Z        = 2;
  localparam int          FLAG_N        = 3;
  localparam int          FLAG_G        = 4;
  localparam int          FLAG_R        = 5;
  typedef enum logic [3:0] {
    CRE_OP_NONE  = 4'h0,
    CRE_OP_CALL  = 4'h1,
    CRE_OP_RET   = 4'h2,
    CRE_OP_HANDLER_EXIT_OP  = 4'h3,
    CRE_OP_TRAP  = 4'h4,
    CRE_OP_SC    = 4'h5,
    CRE_OP_RC    = 4'h6,
    CRE_OP_LDC   = 4'h7,
    CRE_OP_FLAG_INVERT_OP  = 4'h8,
    CRE_OP_ALU   = 4'h9,
    CRE_OP_GSET  = 4'ha
  } cre_op_t;
  typedef enum logic [2:0] {
    CRE_ST_RUN   = 3'h0,
    CRE_ST_PUSHL = 3'h1,
    CRE_ST_PUSHH = 3'h2,
    CRE_ST_VECL  = 3'h3,
    CRE_ST_VECH  = 3'h4,
    CRE_ST_PULLH = 3'h5,
    CRE_ST_PULLL = 3'h6
  } cre_state_t;
endpackage

// ### testbench/cre_core_regs_asserts.sv
// Port checker for the core register and interrupt entry block
`timescale 1ns/10ps
`default_nettype none
module cre_core_regs_asserts (
  input wire logic             core_clk,
  input wire logic             rst_n,
  input wire logic             instr_done,
  input wire cre_pkg::cre_op_t op,
  input wire logic [7:0]       idx_offset,
  input wire logic             alu_upd,
  input wire logic [7:0]       alu_result,
  input wire logic             wakeup_irq,
  input wire logic [7:0]       mem_addr,
  input wire logic [7:0]       mem_rdata,
  input wire logic [11:0]      bus_addr,
  input wire logic             bus_we,
  input wire logic [11:0]      eff_addr,
  input wire logic [10:0]      idx_ff,
  input wire logic [3:0]       stack_index_ff,
  input wire logic [7:0]       flags_word,
  input wire logic             seq_busy,
  input wire logic [2:0]       serving_src_ff
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  property p_eff;
    eff_addr == {idx_ff[10], idx_ff[10], 10'(idx_ff[9:0] + idx_offset)};
  endproperty
  property p_hi;
    mem_addr == cre_pkg::ADDR_IDX_HI |-> mem_rdata == {6'h0, idx_ff[9:8]};
  endproperty
  property p_len;
    $rose(seq_busy) && bus_we && $past(op) != cre_pkg::CRE_OP_CALL |->
      seq_busy[*5] ##1 !seq_busy;
  endproperty
  property p_push;
    $rose(seq_busy) && bus_we |-> bus_addr == {8'h03, $past(stack_index_ff)}
      ##1 bus_we && bus_addr == {8'h03, $past(stack_index_ff, 2) - 4'h1};
  endproperty
  property p_sp;
    $rose(seq_busy) && bus_we |->
      ##2 stack_index_ff == $past(stack_index_ff, 2) - 4'h2;
  endproperty
  property p_gclr;
    $rose(seq_busy) && bus_we && $past(op) != cre_pkg::CRE_OP_CALL |->
      ##5 !flags_word[cre_pkg::FLAG_G];
  endproperty
  property p_mask;
    $rose(seq_busy) && bus_we && !$past(flags_word[cre_pkg::FLAG_G]) &&
      $past(op) != cre_pkg::CRE_OP_CALL |-> ##5 serving_src_ff == 3'h5;
  endproperty
  property p_pri;
    $rose(seq_busy) && bus_we && $past(wakeup_irq) &&
      $past(op) != cre_pkg::CRE_OP_CALL |->
      ##5 serving_src_ff inside {3'h4, 3'h5};
  endproperty
  property p_handler_exit_op;
    instr_done && !seq_busy && op == cre_pkg::CRE_OP_HANDLER_EXIT_OP |=>
      seq_busy[*2] ##1 flags_word[cre_pkg::FLAG_G] &&
      stack_index_ff == $past(stack_index_ff, 3) + 4'h2;
  endproperty
  property p_zn;
    instr_done && !seq_busy && alu_upd |=>
      flags_word[cre_pkg::FLAG_Z] == ($past(alu_result) == 8'h00) &&
      flags_word[cre_pkg::FLAG_N] == $past(alu_result[7]);
  endproperty
  property p_call;
    instr_done && !seq_busy && op == cre_pkg::CRE_OP_CALL |=>
      bus_we ##1 bus_we ##1 !seq_busy;
  endproperty
  a_eff: assert property (p_eff) else $error("indexed address");
  a_hi: assert property (p_hi) else $error("upper index read");
  a_len: assert property (p_len) else $error("entry length");
  a_push: assert property (p_push) else $error("push order");
  a_sp: assert property (p_sp) else $error("push stack index");
  a_gclr: assert property (p_gclr) else $error("mask after entry");
  a_mask: assert property (p_mask) else $error("masked entry");
  a_pri: assert property (p_pri) else $error("wakeup priority");
  a_handler_exit_op: assert property (p_handler_exit_op) else $error("handler exit");
  a_zn: assert property (p_zn) else $error("zero or negative");
  a_call: assert property (p_call) else $error("call push");
  c_entry: cover property ($rose(seq_busy) && bus_we);
  c_handler_exit_op: cover property (instr_done && op == cre_pkg::CRE_OP_HANDLER_EXIT_OP);
  c_trap: cover property (serving_src_ff == 3'h5);
  c_call: cover property (instr_done && op == cre_pkg::CRE_OP_CALL);
endmodule
bind cre_core_regs cre_core_regs_asserts u_cre_core_regs_asserts (.*);
`default_nettype wire

// ### testbench/testbench.sv
// Self-checking bench for the core register and interrupt entry block
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic             core_clk = 1'b0;
  logic             rst_n = 1'b0;
  cre_pkg::cre_op_t op = cre_pkg::CRE_OP_NONE;
  logic             instr_done = 1'b0, alu_upd = 1'b0, alu_upd_c = 1'b0;
  logic             alu_upd_h = 1'b0, alu_carry = 1'b0, alu_half = 1'b0;
  logic             ldc_bit = 1'b0, rot_upd = 1'b0, rot_carry = 1'b0;
  logic             acc_we = 1'b0, idx_load = 1'b0, mem_we = 1'b0;
  logic             ee_ready = 1'b1;
  logic [9:0]       call_target = '0, next_pc = '0;
  logic [7:0]       alu_result = '0, acc_wdata = '0, idx_offset = '0;
  logic [7:0]       mem_addr = '0, mem_wdata = '0;
  logic [10:0]      idx_wdata = '0;
  logic [3:0]       irq = '0;
  wire logic        wakeup_irq, first_timer_irq, pwm_timer_irq, converter_irq;
  wire logic [7:0]  bus_rdata;
  logic [7:0]       mem_rdata, bus_wdata, acc_ff, flags_word;
  logic             mem_hit, bus_we, bus_re, seq_busy;
  logic [11:0]      bus_addr, eff_addr;
  logic [9:0]       fetch_location_ff;
  logic [10:0]      idx_ff;
  logic [3:0]       stack_index_ff;
  logic [2:0]       serving_src_ff;
  logic [7:0]       mem [4096];
  int               checks = 0, n_errors = 0, busy_n = 0;
  assign {wakeup_irq, first_timer_irq, pwm_timer_irq, converter_irq} = irq;
  assign bus_rdata = mem[bus_addr];
  cre_core_regs u_cre_core_regs (.*);
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    if (bus_we) begin
      mem[bus_addr] <= bus_wdata;
    end
  end
  task automatic chk(input string nm, input logic [11:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic run(input cre_pkg::cre_op_t o);
    int n;
    @(posedge core_clk);
    op <= o;
    instr_done <= 1'b1;
    @(posedge core_clk);
    op <= cre_pkg::CRE_OP_NONE;
    instr_done <= 1'b0;
    {alu_upd, alu_upd_c, alu_upd_h, rot_upd, acc_we, idx_load} <= '0;
    #1;
    busy_n = 0;
    for (n = 0; n < 20 && seq_busy !== 1'b0; n++) begin
      busy_n++;
      @(posedge core_clk);
      #1;
    end
    if (n == 20) begin
      n_errors++;
    end
  endtask
  task automatic go(input cre_pkg::cre_op_t o);
    run(o);
    if (busy_n == 0) begin
      run(cre_pkg::CRE_OP_NONE);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(posedge core_clk);
    mem_we <= 1'b1;
    mem_addr <= a;
    mem_wdata <= d;
    @(posedge core_clk);
    mem_we <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, e);
    mem_addr <= a;
    #1;
    chk("rdata", {4'h0, mem_rdata}, {4'h0, e});
  endtask
  task automatic ent(input logic [2:0] s);
    chk("entry cycles", 12'(busy_n), 12'h005);
    chk("source", {9'h0, serving_src_ff}, {9'h0, s});
    chk("vector pc", {2'h0, fetch_location_ff}, {5'h02, s, 4'h0});
    chk("gmask", {11'h0, flags_word[4]}, 12'h000);
  endtask
  task automatic end_of_test;
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    for (int s = 1; s < 6; s++) begin
      mem[12'hff4 + 12'(2 * s)] = 8'(16 * s);
      mem[12'hff5 + 12'(2 * s)] = 8'h01;
    end
  end
  initial begin
    #100000;
    n_errors++;
    end_of_test();
  end
  initial begin
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    #1;
    chk("pc", {2'h0, fetch_location_ff}, 12'h000);
    chk("sp", {8'h0, stack_index_ff}, 12'h00f);
    chk("flags", {4'h0, flags_word}, 12'h020);
    rd(cre_pkg::ADDR_STACK, 8'h0f);
    idx_load <= 1'b1;
    idx_wdata <= 11'h5a3;
    idx_offset <= 8'hff;
    run(cre_pkg::CRE_OP_NONE);
    chk("eff", eff_addr, 12'hea2);
    rd(cre_pkg::ADDR_IDX_HI, 8'h01);
    rd(cre_pkg::ADDR_IDX_LO, 8'ha3);
    wr(cre_pkg::ADDR_IDX_HI, 8'h03);
    chk("idx", {1'b0, idx_ff}, 12'h3a3);
    chk("eff", eff_addr, 12'h0a2);
    rd(8'h00, 8'h00);
    chk("hit", {11'h0, mem_hit}, 12'h000);
    wr(cre_pkg::ADDR_FLAGS, 8'hff);
    chk("flags", {4'h0, flags_word}, 12'h030);
    wr(cre_pkg::ADDR_FLAGS, 8'h00);
    run(cre_pkg::CRE_OP_SC);
    chk("flags", {8'h0, flags_word[3:0]}, 12'h003);
    run(cre_pkg::CRE_OP_RC);
    chk("flags", {8'h0, flags_word[3:0]}, 12'h000);
    ldc_bit <= 1'b1;
    run(cre_pkg::CRE_OP_LDC);
    chk("flags", {8'h0, flags_word[3:0]}, 12'h001);
    run(cre_pkg::CRE_OP_FLAG_INVERT_OP);
    chk("flags", {8'h0, flags_word[3:0]}, 12'h000);
    rot_upd <= 1'b1;
    rot_carry <= 1'b1;
    run(cre_pkg::CRE_OP_NONE);
    chk("flags", {8'h0, flags_word[3:0]}, 12'h001);
    {alu_upd, alu_upd_h, alu_half, alu_result} <= {3'h7, 8'h80};
    run(cre_pkg::CRE_OP_ALU);
    chk("flags", {8'h0, flags_word[3:0]}, 12'h00b);
    {alu_upd, alu_upd_c, alu_carry, alu_result} <= {3'h6, 8'h00};
    run(cre_pkg::CRE_OP_ALU);
    chk("flags", {8'h0, flags_word[3:0]}, 12'h006);
    acc_we <= 1'b1;
    acc_wdata <= 8'h3c;
    call_target <= 10'h155;
    next_pc <= 10'h1c7;
    run(cre_pkg::CRE_OP_CALL);
    chk("acc", {4'h0, acc_ff}, 12'h03c);
    chk("pc", {2'h0, fetch_location_ff}, 12'h155);
    chk("call cycles", 12'(busy_n), 12'h002);
    chk("sp", {8'h0, stack_index_ff}, 12'h00d);
    chk("stack low", {4'h0, mem[12'h03f]}, 12'h0c7);
    chk("stack high", {4'h0, mem[12'h03e]}, 12'h001);
    run(cre_pkg::CRE_OP_RET);
    chk("pc", {2'h0, fetch_location_ff}, 12'h1c7);
    chk("sp", {8'h0, stack_index_ff}, 12'h00f);
    next_pc <= 10'h2a5;
    irq <= 4'h1;
    run(cre_pkg::CRE_OP_NONE);
    chk("masked", 12'(busy_n), 12'h000);
    go(cre_pkg::CRE_OP_GSET);
    ent(3'h1);
    chk("sp", {8'h0, stack_index_ff}, 12'h00d);
    chk("stack low", {4'h0, mem[12'h03f]}, 12'h0a5);
    chk("stack high", {4'h0, mem[12'h03e]}, 12'h002);
    irq <= 4'h0;
    run(cre_pkg::CRE_OP_HANDLER_EXIT_OP);
    chk("pc", {2'h0, fetch_location_ff}, 12'h2a5);
    chk("flags", {4'h0, flags_word}, 12'h036);
    irq <= 4'hf;
    run(cre_pkg::CRE_OP_NONE);
    ent(3'h4);
    for (int s = 4; s >= 1; s--) begin
      run(cre_pkg::CRE_OP_HANDLER_EXIT_OP);
      run(cre_pkg::CRE_OP_NONE);
      ent(3'(s));
      irq[s - 1] <= 1'b0;
    end
    run(cre_pkg::CRE_OP_HANDLER_EXIT_OP);
    chk("sp", {8'h0, stack_index_ff}, 12'h00f);
    wr(cre_pkg::ADDR_FLAGS, 8'h00);
    go(cre_pkg::CRE_OP_TRAP);
    ent(3'h5);
    run(cre_pkg::CRE_OP_RET);
    chk("pc", {2'h0, fetch_location_ff}, 12'h2a5);
    chk("gmask", {11'h0, flags_word[4]}, 12'h000);
    end_of_test();
  end
endmodule
`default_nettype wire
